// ===== jtss_pkg.sv
/*
 * Package for the boundary-scan test access port block: controller states,
 * instruction codes, capture pattern and register lengths.
 * Assumes it is compiled before every file that refers to it.
 */
package jtss_pkg;

	// ----------------------------------------------------------------
	// Controller states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		TEST_LOGIC_RESET,
		RUN_TEST_IDLE,
		SELECT_DR_SCAN,
		CAPTURE_DR,
		SHIFT_DR,
		EXIT1_DR,
		PAUSE_DR,
		EXIT2_DR,
		UPDATE_DR,
		SELECT_IR_SCAN,
		CAPTURE_IR,
		SHIFT_IR,
		EXIT1_IR,
		PAUSE_IR,
		EXIT2_IR,
		UPDATE_IR
	} jtss_state_t;

	// ----------------------------------------------------------------
	// Instruction register
	// ----------------------------------------------------------------
	localparam int          IR_LEN     = 3;
	localparam logic [2:0]  IR_CAPTURE = 3'h4;     // Fixed pattern 100 loaded in Capture-IR.
	// Instruction codes below are arbitrary values.
	localparam logic [2:0]  INSTR_EXTEST = 3'h0;
	localparam logic [2:0]  INSTR_SAMPLE = 3'h1;
	localparam logic [2:0]  INSTR_IDCODE = 3'h2;
	localparam logic [2:0]  INSTR_BYPASS = 3'h7;

	// ----------------------------------------------------------------
	// Data registers and timing
	// ----------------------------------------------------------------
	localparam int          ID_LEN      = 32;
	localparam logic [31:0] ID_VALUE    = 32'h1234_5001;  // Arbitrary identification value.
	localparam logic        BYPASS_CAPT = 1'b0;
	localparam int          TLR_TMS_EDGES = 5;             // TMS-high edges that always reach reset.
	localparam logic [2:0]  TLR_CNT_MAX   = 3'h5;
	localparam int          FIFO_DEPTH  = 32;
	localparam int          BSR_LEN     = 16;

endpackage

// ===== jtag_tap_scan_states.sv
/*
 * Boundary-scan test access port controller with instruction register,
 * bypass, identification and boundary scan registers, and a FIFO that
 * carries boundary-scan update words to the core clock domain, setting updOverflow when a held word is replaced.
 * Assumes tck comes from an external tester and is unrelated to clk, and
 * that the core side drains updData with updValid/updReady.
 */
// Notes on behaviour
// - Pause-DR holds on TMS low, exits high.
// - Exit2-DR goes Update-DR high, Shift-DR low.
// - Boundary output latches only in Update-DR, falling.
// - Update-DR keeps shift stages and instruction.
// - Select-IR goes Capture-IR low, reset high.
// - Select-IR keeps data register and instruction.
// - Capture-IR loads pattern 100 into IR.
// - Capture-IR goes Exit1-IR high, Shift-IR low.
// - Shift-IR shifts IR toward TDO each edge.
// - Shift-IR stays on low, Exit1-IR on high.
// - Exit1-IR goes Update-IR high, Pause-IR low.
// - Pause-IR halts shifting, holds low, exits high.
// - Exit2-IR goes Update-IR high, Shift-IR low.
// - Update-IR latches instruction on falling edge.
// - Update-IR keeps selected data registers.
// - Five TMS-high edges reach reset, loading IDCODE.
// - Exit1-DR goes Update-DR high, Pause-DR low.
`timescale 1ns/1ps

// --------------------------------------------------------------------
// FIFO with registered output stage
// --------------------------------------------------------------------
module jtss_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             rstN,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr;
	logic [AW-1:0]    rdPtr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	// Push when storage has room; pop into the output stage when it is free.
	assign inReady = (count < (AW+1)'(DEPTH));
	assign push    = inValid && inReady;
	assign pop     = (count != '0) && (!outValid || outReady);

	// Storage array write.
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	// Pointers and occupancy; depth is taken as a power of two.
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wrPtr <= wrPtr + AW'(1);
			end
			if (pop) begin
				rdPtr <= rdPtr + AW'(1);
			end
			if (push && !pop) begin
				count <= count + (AW+1)'(1);
			end else if (pop && !push) begin
				count <= count - (AW+1)'(1);
			end
		end
	end

	// Output stage holds its word until the consumer takes it.
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			outData  <= '0;
			outValid <= 1'b0;
		end else if (pop) begin
			outData  <= mem[rdPtr];
			outValid <= 1'b1;
		end else if (outReady) begin
			outValid <= 1'b0;
		end
	end
endmodule

// --------------------------------------------------------------------
// Top: test access port on tck, update stream on clk
// --------------------------------------------------------------------
module jtag_tap_scan_states #(
	parameter int BSR_LEN    = jtss_pkg::BSR_LEN,
	parameter int FIFO_DEPTH = jtss_pkg::FIFO_DEPTH
) (
	input  wire logic               clk,
	input  wire logic               reset_n,
	input  wire logic               tck,
	input  wire logic               tms,
	input  wire logic               tdi,
	output logic                    tdo,
	output logic                    tdoEn,
	output logic      [BSR_LEN-1:0] updData,
	output logic                    updValid,
	input  wire logic               updReady,
	output logic                    updOverflow
);
	jtss_pkg::jtss_state_t state;
	jtss_pkg::jtss_state_t next_state;

	logic                           rstMeta;
	logic                           rstN;
	logic                           tckRstMeta;
	logic                           tckRstN;
	logic [jtss_pkg::IR_LEN-1:0]    irShift;
	logic [jtss_pkg::IR_LEN-1:0]    instr;
	logic                           bypassReg;
	logic [jtss_pkg::ID_LEN-1:0]    idShift;
	logic [BSR_LEN-1:0]             bsrShift;
	logic [BSR_LEN-1:0]             bsrPar;
	logic                           bsrSel;
	logic                           idSel;
	logic                           updToggle;
	logic                           togMeta;
	logic                           togSync;
	logic                           togSeen;
	logic                           pendValid;
	logic [BSR_LEN-1:0]             pendData;
	logic                           fifoInReady;
	logic                           updEvent;
	logic [2:0]                     tmsHighCnt;

	// ----------------------------------------------------------------
	// Reset release in both domains
	// ----------------------------------------------------------------
	// Core reset: asserted at once, released through two flip-flops.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rstMeta <= 1'b0;
			rstN    <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstN    <= rstMeta;
		end
	end

	// Test-port reset: released on tck so the controller leaves reset cleanly.
	always_ff @(posedge tck or negedge reset_n) begin
		if (!reset_n) begin
			tckRstMeta <= 1'b0;
			tckRstN    <= 1'b0;
		end else begin
			tckRstMeta <= 1'b1;
			tckRstN    <= tckRstMeta;
		end
	end

	// ----------------------------------------------------------------
	// Controller state graph
	// ----------------------------------------------------------------
	// Next state from TMS, sampled at each rising tck.
	always_comb begin
		next_state = state;
		case (state)
			jtss_pkg::TEST_LOGIC_RESET: next_state = tms ? jtss_pkg::TEST_LOGIC_RESET : jtss_pkg::RUN_TEST_IDLE;
			jtss_pkg::RUN_TEST_IDLE:    next_state = tms ? jtss_pkg::SELECT_DR_SCAN : jtss_pkg::RUN_TEST_IDLE;
			jtss_pkg::SELECT_DR_SCAN:   next_state = tms ? jtss_pkg::SELECT_IR_SCAN : jtss_pkg::CAPTURE_DR;
			jtss_pkg::CAPTURE_DR:       next_state = tms ? jtss_pkg::EXIT1_DR : jtss_pkg::SHIFT_DR;
			jtss_pkg::SHIFT_DR:         next_state = tms ? jtss_pkg::EXIT1_DR : jtss_pkg::SHIFT_DR;
			jtss_pkg::EXIT1_DR:         next_state = tms ? jtss_pkg::UPDATE_DR : jtss_pkg::PAUSE_DR;
			jtss_pkg::PAUSE_DR:         next_state = tms ? jtss_pkg::EXIT2_DR : jtss_pkg::PAUSE_DR;
			jtss_pkg::EXIT2_DR:         next_state = tms ? jtss_pkg::UPDATE_DR : jtss_pkg::SHIFT_DR;
			jtss_pkg::UPDATE_DR:        next_state = tms ? jtss_pkg::SELECT_DR_SCAN : jtss_pkg::RUN_TEST_IDLE;
			jtss_pkg::SELECT_IR_SCAN:   next_state = tms ? jtss_pkg::TEST_LOGIC_RESET : jtss_pkg::CAPTURE_IR;
			jtss_pkg::CAPTURE_IR:       next_state = tms ? jtss_pkg::EXIT1_IR : jtss_pkg::SHIFT_IR;
			jtss_pkg::SHIFT_IR:         next_state = tms ? jtss_pkg::EXIT1_IR : jtss_pkg::SHIFT_IR;
			jtss_pkg::EXIT1_IR:         next_state = tms ? jtss_pkg::UPDATE_IR : jtss_pkg::PAUSE_IR;
			jtss_pkg::PAUSE_IR:         next_state = tms ? jtss_pkg::EXIT2_IR : jtss_pkg::PAUSE_IR;
			jtss_pkg::EXIT2_IR:         next_state = tms ? jtss_pkg::UPDATE_IR : jtss_pkg::SHIFT_IR;
			jtss_pkg::UPDATE_IR:        next_state = tms ? jtss_pkg::SELECT_DR_SCAN : jtss_pkg::RUN_TEST_IDLE;
			default:                    next_state = jtss_pkg::TEST_LOGIC_RESET;
		endcase
	end

	// State register; five TMS-high edges from any state land in reset.
	always_ff @(posedge tck or negedge tckRstN) begin
		if (!tckRstN) begin
			state <= jtss_pkg::TEST_LOGIC_RESET;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Instruction register
	// ----------------------------------------------------------------
	// Shift stage: pattern in Capture-IR, shift in Shift-IR, hold elsewhere.
	always_ff @(posedge tck or negedge tckRstN) begin
		if (!tckRstN) begin
			irShift <= jtss_pkg::IR_CAPTURE;
		end else if (state == jtss_pkg::CAPTURE_IR) begin
			irShift <= jtss_pkg::IR_CAPTURE;
		end else if (state == jtss_pkg::SHIFT_IR) begin
			irShift <= {tdi, irShift[jtss_pkg::IR_LEN-1:1]};
		end
	end

	// Current instruction changes on falling tck in Update-IR or in reset.
	always_ff @(negedge tck or negedge tckRstN) begin
		if (!tckRstN) begin
			instr <= jtss_pkg::INSTR_IDCODE;
		end else if (state == jtss_pkg::TEST_LOGIC_RESET) begin
			instr <= jtss_pkg::INSTR_IDCODE;
		end else if (state == jtss_pkg::UPDATE_IR) begin
			instr <= irShift;
		end
	end

	// Data register selection decoded from the current instruction.
	assign bsrSel = (instr == jtss_pkg::INSTR_EXTEST) || (instr == jtss_pkg::INSTR_SAMPLE);
	assign idSel  = (instr == jtss_pkg::INSTR_IDCODE);

	// ----------------------------------------------------------------
	// Data registers
	// ----------------------------------------------------------------
	// Shift stages move only in Capture-DR and Shift-DR; all other states hold.
	always_ff @(posedge tck or negedge tckRstN) begin
		if (!tckRstN) begin
			bypassReg <= jtss_pkg::BYPASS_CAPT;
			idShift   <= jtss_pkg::ID_VALUE;
			bsrShift  <= '0;
		end else if (state == jtss_pkg::CAPTURE_DR) begin
			if (bsrSel) begin
				bsrShift <= bsrPar;
			end else if (idSel) begin
				idShift <= jtss_pkg::ID_VALUE;
			end else begin
				bypassReg <= jtss_pkg::BYPASS_CAPT;
			end
		end else if (state == jtss_pkg::SHIFT_DR) begin
			if (bsrSel) begin
				bsrShift <= {tdi, bsrShift[BSR_LEN-1:1]};
			end else if (idSel) begin
				idShift <= {tdi, idShift[jtss_pkg::ID_LEN-1:1]};
			end else begin
				bypassReg <= tdi;
			end
		end
	end

	// Latched boundary output changes only on falling tck in Update-DR.
	always_ff @(negedge tck or negedge tckRstN) begin
		if (!tckRstN) begin
			bsrPar    <= '0;
			updToggle <= 1'b0;
		end else if ((state == jtss_pkg::UPDATE_DR) && bsrSel) begin
			bsrPar    <= bsrShift;
			updToggle <= ~updToggle;
		end
	end

	// Serial output is driven on falling tck while a shift state is active.
	always_ff @(negedge tck or negedge tckRstN) begin
		if (!tckRstN) begin
			tdo   <= 1'b0;
			tdoEn <= 1'b0;
		end else begin
			tdoEn <= (state == jtss_pkg::SHIFT_DR) || (state == jtss_pkg::SHIFT_IR);
			if (state == jtss_pkg::SHIFT_IR) begin
				tdo <= irShift[0];
			end else if (bsrSel) begin
				tdo <= bsrShift[0];
			end else if (idSel) begin
				tdo <= idShift[0];
			end else begin
				tdo <= bypassReg;
			end
		end
	end

	// ----------------------------------------------------------------
	// Update stream into the core domain
	// ----------------------------------------------------------------
	// Toggle crossing; bsrPar stays still for many tck cycles after a toggle.
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			togMeta <= 1'b0;
			togSync <= 1'b0;
			togSeen <= 1'b0;
		end else begin
			togMeta <= updToggle;
			togSync <= togMeta;
			togSeen <= togSync;
		end
	end

	assign updEvent = togSync ^ togSeen;

	// One-word holding stage; a new word while a word is held and the FIFO stalls is flagged.
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			pendValid   <= 1'b0;
			pendData    <= '0;
			updOverflow <= 1'b0;
		end else begin
			if (updEvent) begin
				pendData  <= bsrPar;
				pendValid <= 1'b1;
				if (pendValid && !fifoInReady) begin
					updOverflow <= 1'b1;
				end
			end else if (fifoInReady) begin
				pendValid <= 1'b0;
			end
		end
	end

	// Buffer between the holding stage and the core consumer.
	jtss_fifo #(
		.WIDTH (BSR_LEN),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk      (clk),
		.rstN     (rstN),
		.inData   (pendData),
		.inValid  (pendValid),
		.inReady  (fifoInReady),
		.outData  (updData),
		.outValid (updValid),
		.outReady (updReady)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Consecutive TMS-high edges, saturating, for the reset check.
	always_ff @(posedge tck or negedge tckRstN) begin
		if (!tckRstN) begin
			tmsHighCnt <= '0;
		end else if (!tms) begin
			tmsHighCnt <= '0;
		end else if (tmsHighCnt != jtss_pkg::TLR_CNT_MAX) begin
			tmsHighCnt <= tmsHighCnt + 3'h1;
		end
	end

	chk_pause_dr_move: assert property (@(posedge tck) disable iff (!tckRstN)
		state == jtss_pkg::PAUSE_DR |=> state == (($past(tms)) ? jtss_pkg::EXIT2_DR : jtss_pkg::PAUSE_DR)
		&& $stable(bsrShift))
		else $error("Pause-DR step wrong or data shifted.");
	chk_exit2_dr_move: assert property (@(posedge tck) disable iff (!tckRstN)
		(state == jtss_pkg::EXIT2_DR) && tms |=> state == jtss_pkg::UPDATE_DR)
		else $error("Exit2-DR with TMS high did not reach Update-DR.");
	chk_bsr_out_hold: assert property (@(negedge tck) disable iff (!tckRstN)
		(state != jtss_pkg::UPDATE_DR) || !bsrSel |=> $stable(bsrPar))
		else $error("Boundary output changed outside Update-DR.");
	chk_dr_hold_idle: assert property (@(posedge tck) disable iff (!tckRstN)
		!(state inside {jtss_pkg::CAPTURE_DR, jtss_pkg::SHIFT_DR}) |=> $stable(bsrShift) && $stable(idShift))
		else $error("Data register moved outside capture or shift.");
	chk_sel_ir_move: assert property (@(posedge tck) disable iff (!tckRstN)
		state == jtss_pkg::SELECT_IR_SCAN ##1 !$past(tms) |-> state == jtss_pkg::CAPTURE_IR)
		else $error("Select-IR with TMS low did not reach Capture-IR.");
	chk_capture_ir_load: assert property (@(posedge tck) disable iff (!tckRstN)
		state == jtss_pkg::CAPTURE_IR |=> irShift == jtss_pkg::IR_CAPTURE)
		else $error("Capture-IR did not load the fixed pattern.");
	chk_shift_ir_step: assert property (@(posedge tck) disable iff (!tckRstN)
		state == jtss_pkg::SHIFT_IR |=> irShift == {$past(tdi), $past(irShift[jtss_pkg::IR_LEN-1:1])})
		else $error("Shift-IR did not shift one stage.");
	chk_ir_exit_path: assert property (@(posedge tck) disable iff (!tckRstN)
		(state inside {jtss_pkg::EXIT1_IR, jtss_pkg::EXIT2_IR}) && tms |=> state == jtss_pkg::UPDATE_IR)
		else $error("IR exit with TMS high did not reach Update-IR.");
	chk_pause_ir_hold: assert property (@(posedge tck) disable iff (!tckRstN)
		((state == jtss_pkg::PAUSE_IR) && !tms) [*2] |=> state == jtss_pkg::PAUSE_IR && $stable(irShift))
		else $error("Pause-IR did not hold.");
	chk_instr_change: assert property (@(posedge tck) disable iff (!tckRstN)
		$changed(instr) |-> state inside {jtss_pkg::UPDATE_IR, jtss_pkg::TEST_LOGIC_RESET})
		else $error("Instruction changed outside Update-IR or reset.");
	chk_tms_reset: assert property (@(posedge tck) disable iff (!tckRstN)
		tmsHighCnt == jtss_pkg::TLR_CNT_MAX |-> state == jtss_pkg::TEST_LOGIC_RESET)
		else $error("Five TMS-high edges did not reach reset.");
	chk_update_exit: assert property (@(posedge tck) disable iff (!tckRstN)
		(state inside {jtss_pkg::UPDATE_DR, jtss_pkg::UPDATE_IR}) && !tms |=> state == jtss_pkg::RUN_TEST_IDLE)
		else $error("Update with TMS low did not reach Run-Test/Idle.");

endmodule

// ===== jtss_tester.sv
/*
 * Tester model for the far side of the test access port: makes tck,
 * drives tms and tdi, and samples tdo.
 * Assumes the device moves on rising tck and drives tdo after falling tck.
 */
`timescale 1ns/1ps

module jtss_tester (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo
);
	// ------------------------------------------------------------------
	// Link stepping
	// ------------------------------------------------------------------
	// Clock rests low between frames.
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// One tck period: inputs change while low, tdo is taken just before the rise.
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#7.5;
		o = tdo;
		tck = 1'b1;
		#7.5;
		tck = 1'b0;
	endtask

	// An edge whose tdi is not shifted shows the inverse of the last value.
	task automatic idle(input logic m);
		logic o;
		step(m, ~tdi, o);
	endtask

	// ------------------------------------------------------------------
	// Scans
	// ------------------------------------------------------------------
	// Scan from Run-Test/Idle and back; an optional pause follows bit pz-1, after the first pz bits.
	task automatic scan(input logic ir, input int n, input logic [31:0] din, input int pz,
		output logic [31:0] dout);
		logic o;
		dout = '0;
		idle(1'b1);
		if (ir) begin
			idle(1'b1);
		end
		idle(1'b0);
		idle(1'b0);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1 || i == pz - 1, din[i], o);
			dout[i] = o;
			if (i == pz - 1 && i != n - 1) begin
				repeat (4) idle(1'b0);
				idle(1'b1);
				idle(1'b0);
			end
		end
		idle(1'b1);
		idle(1'b0);
	endtask

	// Five high edges reach reset from anywhere; one low edge parks in idle.
	task automatic reset_walk();
		repeat (5) idle(1'b1);
		idle(1'b0);
	endtask
endmodule

// ===== tb_top.sv
/*
 * Self-checking bench for the test access port and its update stream.
 * Assumes the tester model drives the link and the bench drains the stream.
 */
`timescale 1ns/1ps

module tb_top;
	logic        clk;
	logic        reset_n;
	logic        tck;
	logic        tms;
	logic        tdi;
	logic        tdo;
	logic        tdoEn;
	logic [15:0] updData;
	logic        updValid;
	logic        updReady;
	logic        updOverflow;
	logic        readyRandom;
	logic        haveLast;
	logic [31:0] lastWord;
	logic [31:0] rng;
	logic [31:0] expQ[$];
	int          failCount;
	int          checks;

	jtag_tap_scan_states u_dut (
		.clk         (clk),
		.reset_n     (reset_n),
		.tck         (tck),
		.tms         (tms),
		.tdi         (tdi),
		.tdo         (tdo),
		.tdoEn       (tdoEn),
		.updData     (updData),
		.updValid    (updValid),
		.updReady    (updReady),
		.updOverflow (updOverflow)
	);

	jtss_tester u_tester (
		.tck (tck),
		.tms (tms),
		.tdi (tdi),
		.tdo (tdo)
	);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Core clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Xorshift source, repeatable from its fixed seed.
	function automatic logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	// Counts a comparison and reports a difference.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failCount++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, failCount);
		if (failCount == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Loads an instruction through six shifts, checking the capture pattern.
	task automatic load_ir(input logic [2:0] code);
		logic [31:0] o;
		logic [2:0]  j;
		j = 3'(rnd());
		u_tester.scan(1'b1, 6, {26'h0, code, j}, int'(rnd() % 7), o);
		check(o, {26'h0, j, jtss_pkg::IR_CAPTURE});
	endtask

	// Boundary scan: capture shows the previous latched word, update sends a new one.
	task automatic ext_scan();
		logic [31:0] o;
		logic [31:0] w;
		w = rnd() & 32'hffff;
		expQ.push_back(w);
		u_tester.scan(1'b0, 16, w, int'(rnd() % 17), o);
		if (haveLast) begin
			check(o, lastWord);
		end
		haveLast = 1'b1;
		lastWord = w;
	endtask

	// Identification scan.
	task automatic id_scan();
		logic [31:0] o;
		u_tester.scan(1'b0, 32, rnd(), 0, o);
		check(o, jtss_pkg::ID_VALUE);
	endtask

	// Lets the stream empty under a bounded wait.
	task automatic drain();
		int k;
		k = 0;
		readyRandom = 1'b1;
		while (expQ.size() != 0 && k < 3000) begin
			@(posedge clk);
			k++;
		end
		if (expQ.size() != 0) begin
			check(32'h1, 32'h0);
			test_done();
		end
		repeat (10) @(posedge clk);
		check({31'h0, updValid}, 32'h0);
	endtask

	// Steps the link through a tms pattern, bit 0 first.
	task automatic walk(input logic [7:0] pat, input int n);
		for (int i = 0; i < n; i++) begin
			u_tester.idle(pat[i]);
		end
	endtask

	// ------------------------------------------------------------------
	// Stream side
	// ------------------------------------------------------------------
	// Consumer stalls at random; words must arrive only as expected.
	always @(negedge clk) begin
		updReady <= readyRandom && (rnd() & 32'h3) != 32'h0;
	end

	always @(posedge clk) begin
		if (reset_n === 1'b1 && updValid === 1'b1 && updReady === 1'b1) begin
			check({31'h0, expQ.size() != 0}, 32'h1);
			if (expQ.size() != 0) begin
				check({16'h0, updData}, expQ.pop_front());
			end
		end
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		logic [31:0] o;
		logic [31:0] w;
		reset_n = 1'b0;
		readyRandom = 1'b1;
		haveLast = 1'b0;
		lastWord = '0;
		rng = 32'h3f84408f;
		failCount = 0;
		checks = 0;
		repeat (6) @(negedge clk);
		reset_n = 1'b1;
		#1.3;
		u_tester.reset_walk();
		id_scan();
		load_ir(jtss_pkg::INSTR_BYPASS);
		w = rnd();
		u_tester.scan(1'b0, 8, w, 3, o);
		check(o, {24'h0, w[6:0], jtss_pkg::BYPASS_CAPT});
		load_ir(jtss_pkg::INSTR_EXTEST);
		ext_scan();
		ext_scan();
		load_ir(jtss_pkg::INSTR_BYPASS);
		u_tester.scan(1'b0, 16, rnd(), 5, o);
		load_ir(jtss_pkg::INSTR_SAMPLE);
		ext_scan();
		// Select-IR-Scan with tms high falls back to reset.
		walk(8'h07, 4);
		id_scan();
		// Five high edges from inside Shift-IR also reach reset; the port drives only while shifting.
		walk(8'h03, 4);
		#1;
		check({31'h0, tdoEn}, 32'h1);
		check({31'h0, tdo}, {31'h0, jtss_pkg::IR_CAPTURE[0]});
		u_tester.reset_walk();
		#1;
		check({31'h0, tdoEn}, 32'h0);
		id_scan();
		drain();
		// Fill the stream until it overflows; the newest word replaces the held one.
		load_ir(jtss_pkg::INSTR_EXTEST);
		readyRandom = 1'b0;
		repeat (34) ext_scan();
		repeat (10) @(posedge clk);
		check({31'h0, updOverflow}, 32'h0);
		ext_scan();
		w = expQ.pop_back();
		void'(expQ.pop_back());
		expQ.push_back(w);
		repeat (10) @(posedge clk);
		check({31'h0, updOverflow}, 32'h1);
		drain();
		test_done();
	end
endmodule
